// file: hdl/crf_defs.svh
// Purpose: Constants for the core register file.
// Assumes: Included by bare name from hdl/.
// Notes:   Status word bit positions follow the core layout.
`ifndef CRF_DEFS_SVH
`define CRF_DEFS_SVH

`define CRF_IDX_PC       4'h0
`define CRF_IDX_SP       4'h1
`define CRF_IDX_SR       4'h2
`define CRF_IDX_CG       4'h3

`define CRF_SR_C         0
`define CRF_SR_Z         1
`define CRF_SR_N         2
`define CRF_SR_GIE       3
`define CRF_SR_HALT      4
`define CRF_SR_XSTOP     5
`define CRF_SR_LOOPOFF   6
`define CRF_SR_DCOFF     7
`define CRF_SR_V         8

`define CRF_RESET_VAL    16'h0000
`define CRF_CONST_FOUR   16'h0004
`define CRF_CONST_EIGHT  16'h0008
`define CRF_CONST_ONE    16'h0001
`define CRF_CONST_TWO    16'h0002
`define CRF_CONST_ONES   16'hFFFF
`define CRF_WORD_STEP    16'h0002

`endif

// file: hdl/crf_pkg.sv
// Purpose: Types for the core register file.
// Assumes: Nothing beyond the defines header.
// Notes:   Operation codes are local to this block.
package crf_pkg;
    typedef enum logic [2:0] {
        CRF_OP_MOV,
        CRF_OP_ADD,
        CRF_OP_ADDC,
        CRF_OP_SUB,
        CRF_OP_SUBC,
        CRF_OP_CMP,
        CRF_OP_LOGIC
    } crf_op_t;

    typedef enum logic [1:0] {
        CRF_SP_NONE,
        CRF_SP_PUSH,
        CRF_SP_POP
    } crf_sp_t;
endpackage

// file: hdl/crf_core_regs.sv
// Purpose: Sixteen-entry register file with program counter, stack pointer,
//          status word, constant sources and flag logic.
// Assumes: The sequencer presents one register operation per cycle.
// Notes:   Memory accesses for the stack are made by the sequencer.
//          Interrupt entry only clears the halt, dc and crystal bits here; pushing the
//          program counter and status word is left to the sequencer.
//          Register three keeps no value worth reading: its slot is held at zero.
//          Stack pointer alignment is left to software, as the core never checks it.
// Behaviour
// - Sixteen 16-bit registers, four dedicated.
// - Program counter advances by instruction length.
// - Program counter stays even in 64-KB.
// - Program counter readable, writing it branches.
// - Stack pointer predecrements on push, postincrements on pop.
// - Push of stack pointer leaves it decremented.
// - Pop into stack pointer takes popped value.
// - Status word is written only in word register mode; byte register reads give its low byte.
// - Overflow flag set on signed overflow.
// - Second clock bit stops dc generator conditionally.
// - First clock bit stops loop control.
// - Crystal stop bit stops crystal conditionally.
// - Halt bit stops the core.
// - Global enable gates maskable interrupts.
// - Negative flag copies result top bit.
// - Zero flag marks zero result.
// - Carry flag marks carry out.
// - Register two supplies zero, four, eight.
// - Register three supplies zero, one, two, ones.
// - Constant registers are source only.
// - Register operations take one cycle, word or byte.
// - Interrupt entry clears halt, dc and crystal bits.
// - Register three mode zero gives zero.
`timescale 1ns/10ps
`include "crf_defs.svh"

module crf_core_regs
    import crf_pkg::*;
#(
    parameter int NUM_REGS = 16,
    parameter int WIDTH    = 16
) (
    // Clock and reset
    input  wire logic              i_clk,
    input  wire logic              i_rst_b,
    // Operation request
    input  wire logic              i_op_valid,
    input  wire crf_op_t           i_op,
    input  wire logic              i_byte_op,
    input  wire logic [3:0]        i_src_reg,
    input  wire logic [1:0]        i_source_mode_bits,
    input  wire logic [3:0]        i_dst_reg,
    input  wire logic              i_dst_write,
    input  wire logic [WIDTH-1:0]  i_logic_result,
    // Program counter and stack control
    input  wire logic [2:0]        i_instr_len,
    input  wire logic              i_instr_done,
    input  wire crf_sp_t           i_sp_op,
    input  wire logic [WIDTH-1:0]  i_pop_data,
    input  wire logic              i_irq_entry,
    // Clock system status
    input  wire logic              i_dco_in_use,
    input  wire logic              i_xtal_in_use,
    input  wire logic              i_maskable_irq,
    // Results
    output logic [WIDTH-1:0]       o_src_data,
    output logic [WIDTH-1:0]       o_program_counter,
    output logic [WIDTH-1:0]       o_stack_pointer,
    output logic [WIDTH-1:0]       o_status_word,
    // Clock system and core control
    output logic                   o_core_halt,
    output logic                   o_dc_generator_off,
    output logic                   o_loop_control_off,
    output logic                   o_crystal_stop,
    output logic                   o_irq_accept
);

    // ************************************************************
    // Elaboration checks
    // ************************************************************
    if (NUM_REGS != 16 || WIDTH != 16) begin : g_bad_param
        $error("crf_core_regs supports only sixteen 16-bit registers.");
    end

    // ************************************************************
    // Storage
    // ************************************************************
    // Every slot is a plain flip-flop word, so a register operation reads and
    // writes within a single cycle with no memory macro latency.
    logic [WIDTH-1:0] regs_q [NUM_REGS];
    logic [WIDTH-1:0] regs_d [NUM_REGS];

    // ************************************************************
    // Source selection and constant sources
    // ************************************************************
    wire        src_is_sr  = (i_src_reg == `CRF_IDX_SR);
    wire        src_is_cg  = (i_src_reg == `CRF_IDX_CG);
    wire        sr_reg_use = (i_source_mode_bits == 2'b00) && !i_byte_op;
    // Constant sources win over storage so that no stale word of register two
    // or three can leak into an operand in a constant mode.
    logic [WIDTH-1:0] src_raw;
    always_comb begin
        src_raw = regs_q[i_src_reg];
        if (src_is_cg) begin
            unique case (i_source_mode_bits)
                2'b00: src_raw = `CRF_RESET_VAL;
                2'b01: src_raw = `CRF_CONST_ONE;
                2'b10: src_raw = `CRF_CONST_TWO;
                2'b11: src_raw = `CRF_CONST_ONES;
            endcase
        end else if (src_is_sr && !sr_reg_use) begin
            unique case (i_source_mode_bits)
                2'b00: src_raw = regs_q[`CRF_IDX_SR];
                2'b01: src_raw = `CRF_RESET_VAL;
                2'b10: src_raw = `CRF_CONST_FOUR;
                2'b11: src_raw = `CRF_CONST_EIGHT;
            endcase
        end
    end
    // Byte operands see a cleared high byte.
    wire [WIDTH-1:0] src_val = i_byte_op ? {8'h00, src_raw[7:0]} : src_raw;
    wire [WIDTH-1:0] dst_raw = regs_q[i_dst_reg];
    wire [WIDTH-1:0] dst_val = i_byte_op ? {8'h00, dst_raw[7:0]} : dst_raw;

    // ************************************************************
    // Arithmetic and flags
    // ************************************************************
    wire        is_sub   = (i_op == CRF_OP_SUB) || (i_op == CRF_OP_SUBC) || (i_op == CRF_OP_CMP);
    wire        use_c    = (i_op == CRF_OP_ADDC) || (i_op == CRF_OP_SUBC);
    wire        is_arith = (i_op != CRF_OP_MOV) && (i_op != CRF_OP_LOGIC);
    wire        cin      = use_c ? regs_q[`CRF_IDX_SR][`CRF_SR_C] : is_sub;
    wire [WIDTH-1:0] opnd_b  = is_sub ? ~src_val : src_val;
    // One adder serves both directions: a subtraction adds the inverted source
    // plus one, so the carry out reads as no borrow.
    wire [WIDTH:0]   sum     = {1'b0, dst_val} + {1'b0, opnd_b} + {16'h0000, cin};
    wire [WIDTH-1:0] res_full = is_arith ? sum[WIDTH-1:0] :
                                (i_op == CRF_OP_MOV) ? src_val : i_logic_result;
    wire [WIDTH-1:0] res     = i_byte_op ? {8'h00, res_full[7:0]} : res_full;
    wire        msb_res  = i_byte_op ? res[7] : res[15];
    wire        msb_a    = i_byte_op ? dst_val[7] : dst_val[15];
    wire        msb_b    = i_byte_op ? opnd_b[7] : opnd_b[15];
    // A byte carry comes out of bit 7, which the word adder does not expose.
    wire        carry    = i_byte_op ? (dst_val[7:0] + opnd_b[7:0] + {7'h00, cin} > 9'h0FF)
                                     : sum[WIDTH];
    // Same-sign inputs to the adder yielding the other sign is overflow in both directions.
    wire        ovf      = (msb_a == msb_b) && (msb_res != msb_a);
    wire        zero     = (res == `CRF_RESET_VAL);
    wire        set_flags = i_op_valid && is_arith;
    // A compare only sets flags, and register three has nothing to store, so
    // neither may reach the destination.
    wire        writes   = i_op_valid && i_dst_write && (i_op != CRF_OP_CMP)
                           && (i_dst_reg != `CRF_IDX_CG);

    // ************************************************************
    // Next state
    // ************************************************************
    wire [WIDTH-1:0] sp_dec = regs_q[`CRF_IDX_SP] - `CRF_WORD_STEP;
    wire [WIDTH-1:0] sp_inc = regs_q[`CRF_IDX_SP] + `CRF_WORD_STEP;
    wire [WIDTH-1:0] pc_next = regs_q[`CRF_IDX_PC] + {13'h0000, i_instr_len};
    // The enable bit in force before this edge gates the request.
    wire             take_irq = i_maskable_irq && regs_q[`CRF_IDX_SR][`CRF_SR_GIE];

    // Later assignments take priority: a destination write beats the stack step,
    // a pop into the stack pointer beats the write, and interrupt entry clears
    // its low-power bits last so that no write in the same cycle can keep the
    // core asleep.
    always_comb begin
        for (int i = 0; i < NUM_REGS; i++) begin
            regs_d[i] = regs_q[i];
        end
        if (i_instr_done) begin
            regs_d[`CRF_IDX_PC] = pc_next;
        end
        if (set_flags) begin
            regs_d[`CRF_IDX_SR][`CRF_SR_C] = carry;
            regs_d[`CRF_IDX_SR][`CRF_SR_Z] = zero;
            regs_d[`CRF_IDX_SR][`CRF_SR_N] = msb_res;
            regs_d[`CRF_IDX_SR][`CRF_SR_V] = ovf;
        end
        unique case (i_sp_op)
            CRF_SP_PUSH: regs_d[`CRF_IDX_SP] = sp_dec;
            CRF_SP_POP:  regs_d[`CRF_IDX_SP] = sp_inc;
            default:     regs_d[`CRF_IDX_SP] = regs_q[`CRF_IDX_SP];
        endcase
        if (writes && !(i_dst_reg == `CRF_IDX_SR && i_byte_op)) begin
            regs_d[i_dst_reg] = res;
        end
        if (i_sp_op == CRF_SP_POP && i_dst_reg == `CRF_IDX_SP && i_dst_write) begin
            regs_d[`CRF_IDX_SP] = i_pop_data;
        end
        if (i_irq_entry) begin
            regs_d[`CRF_IDX_SR][`CRF_SR_HALT]  = 1'b0;
            regs_d[`CRF_IDX_SR][`CRF_SR_DCOFF] = 1'b0;
            regs_d[`CRF_IDX_SR][`CRF_SR_XSTOP] = 1'b0;
        end
        // Forcing bit zero last keeps the counter even whatever was written.
        regs_d[`CRF_IDX_PC][0] = 1'b0;
        regs_d[`CRF_IDX_CG]    = `CRF_RESET_VAL;
    end

    // ************************************************************
    // Registers
    // ************************************************************
    // One process per slot keeps each register a separate flop word, which
    // keeps the write enable of every slot easy to trace.
    genvar g;
    for (g = 0; g < NUM_REGS; g++) begin : g_reg
        always_ff @(posedge i_clk or negedge i_rst_b) begin
            if (!i_rst_b) begin
                regs_q[g] <= `CRF_RESET_VAL;
            end else begin
                regs_q[g] <= regs_d[g];
            end
        end
    end

    // ************************************************************
    // Output decode
    // ************************************************************
    // The visible copies take the next-state values so that each output equals
    // its register right after the edge, with no extra cycle of lag.
    wire [WIDTH-1:0] pc_d       = regs_d[`CRF_IDX_PC];
    wire [WIDTH-1:0] sp_d       = regs_d[`CRF_IDX_SP];
    wire [WIDTH-1:0] sw_d       = regs_d[`CRF_IDX_SR];
    wire             halt_d     = sw_d[`CRF_SR_HALT];
    // A source that still feeds the main or sub-main clock must keep running,
    // so its stop request is masked while it is in use.
    wire             dc_off_d   = sw_d[`CRF_SR_DCOFF] && !i_dco_in_use;
    wire             loop_off_d = sw_d[`CRF_SR_LOOPOFF];
    wire             xstop_d    = sw_d[`CRF_SR_XSTOP] && !i_xtal_in_use;

    // ************************************************************
    // Output registers
    // ************************************************************
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_src_data <= `CRF_RESET_VAL;
        end else begin
            o_src_data <= src_val;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_program_counter <= `CRF_RESET_VAL;
        end else begin
            o_program_counter <= pc_d;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_stack_pointer <= `CRF_RESET_VAL;
        end else begin
            o_stack_pointer <= sp_d;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_status_word <= `CRF_RESET_VAL;
        end else begin
            o_status_word <= sw_d;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_core_halt <= 1'b0;
        end else begin
            o_core_halt <= halt_d;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_dc_generator_off <= 1'b0;
        end else begin
            o_dc_generator_off <= dc_off_d;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_loop_control_off <= 1'b0;
        end else begin
            o_loop_control_off <= loop_off_d;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_crystal_stop <= 1'b0;
        end else begin
            o_crystal_stop <= xstop_d;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_irq_accept <= 1'b0;
        end else begin
            o_irq_accept <= take_irq;
        end
    end

endmodule

// file: bench/crf_core_regs_checker.sv
// Purpose: Port assertions for the core register file.
// Assumes: Bound to crf_core_regs with a 16-bit word.
// Notes:   One clock domain, so default clocking is used.
`timescale 1ns/10ps
module crf_core_regs_checker
    import crf_pkg::*;
(
    input wire logic        i_clk, i_rst_b, i_op_valid, i_byte_op, i_dst_write, i_instr_done,
    input wire logic        i_irq_entry, i_maskable_irq, o_core_halt, o_dc_generator_off,
    input wire logic        o_crystal_stop, o_loop_control_off, o_irq_accept,
    input wire logic [3:0]  i_src_reg, i_dst_reg,
    input wire logic [1:0]  i_source_mode_bits,
    input wire logic [2:0]  i_instr_len,
    input wire crf_sp_t     i_sp_op,
    input wire logic [15:0] i_pop_data, o_src_data, o_program_counter, o_stack_pointer, o_status_word
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    property p_pc_even; o_program_counter[0] == 1'h0; endproperty
    a_pc_even: assert property (p_pc_even) else $error("program counter odd");
    property p_pc_step; i_instr_done && !(i_op_valid && i_dst_write && i_dst_reg == 4'h0)
        |=> o_program_counter == $past(o_program_counter) + {13'h0, $past(i_instr_len)}; endproperty
    a_pc_step: assert property (p_pc_step) else $error("program counter step wrong");
    property p_push; i_sp_op == CRF_SP_PUSH && !(i_op_valid && i_dst_write && i_dst_reg == 4'h1)
        |=> o_stack_pointer == $past(o_stack_pointer) - 16'h0002; endproperty
    a_push: assert property (p_push) else $error("push did not predecrement");
    property p_pop_sp; i_sp_op == CRF_SP_POP && i_op_valid && i_dst_write && i_dst_reg == 4'h1
        |=> o_stack_pointer == $past(i_pop_data); endproperty
    a_pop_sp: assert property (p_pop_sp) else $error("pop into stack pointer wrong");
    property p_ones; i_op_valid && !i_byte_op && i_src_reg == 4'h3 && i_source_mode_bits == 2'h3
        |=> o_src_data == 16'hFFFF; endproperty
    a_ones: assert property (p_ones) else $error("all ones constant wrong");
    property p_four; i_op_valid && i_src_reg == 4'h2 && i_source_mode_bits == 2'h2
        |=> o_src_data == 16'h0004; endproperty
    a_four: assert property (p_four) else $error("constant four wrong");
    property p_byte; i_op_valid && i_byte_op |=> o_src_data[15:8] == 8'h00; endproperty
    a_byte: assert property (p_byte) else $error("byte source high byte set");
    property p_wake; i_irq_entry |=> !(o_core_halt || o_dc_generator_off || o_crystal_stop); endproperty
    a_wake: assert property (p_wake) else $error("interrupt entry left low power bits");
    property p_gate; !i_maskable_irq |=> !o_irq_accept; endproperty
    a_gate: assert property (p_gate) else $error("interrupt accepted without request");
    property p_loop; o_loop_control_off == o_status_word[6]; endproperty
    a_loop: assert property (p_loop) else $error("loop control output wrong");
endmodule

// file: bench/crf_mem_model.sv
// Purpose: Word memory standing behind the core for stack traffic.
// Assumes: Addresses are byte addresses of even words.
// Notes:   Unwritten words read unknown, as real RAM would hold junk.
`timescale 1ns/10ps
module crf_mem_model (
    input wire logic        i_clk,
    input wire logic        i_we,
    input wire logic [15:0] i_addr,
    input wire logic [15:0] i_wdata,
    output logic [15:0]     o_rdata
);
    logic [15:0] mem [0:32767];
    always_ff @(posedge i_clk) if (i_we) mem[i_addr[15:1]] <= i_wdata;
    assign o_rdata = mem[i_addr[15:1]];
endmodule

// file: bench/crf_core_regs_tb.sv
// Purpose: Self-checking bench for the core register file.
// Assumes: Reset held five cycles, one operation every other cycle.
// Notes:   Stack words live in the memory model.
`timescale 1ns/10ps
module crf_core_regs_tb;
    import crf_pkg::*;
    logic i_clk, i_rst_b, i_op_valid, i_byte_op, i_dst_write, i_instr_done, i_irq_entry, mem_we;
    logic i_dco_in_use, i_xtal_in_use, i_maskable_irq, o_irq_accept;
    logic o_core_halt, o_dc_generator_off, o_loop_control_off, o_crystal_stop;
    crf_op_t     i_op;
    crf_sp_t     i_sp_op;
    logic [3:0]  i_src_reg, i_dst_reg;
    logic [1:0]  i_source_mode_bits;
    logic [2:0]  i_instr_len;
    logic [15:0] i_logic_result, i_pop_data, mem_addr, mem_wdata;
    logic [15:0] o_src_data, o_program_counter, o_stack_pointer, o_status_word;
    int          fails, checks, cyc;
    crf_core_regs u_crf_core_regs (
        .i_clk(i_clk), .i_rst_b(i_rst_b), .i_op_valid(i_op_valid), .i_op(i_op), .i_byte_op(i_byte_op),
        .i_src_reg(i_src_reg), .i_source_mode_bits(i_source_mode_bits), .i_dst_reg(i_dst_reg),
        .i_dst_write(i_dst_write), .i_logic_result(i_logic_result), .i_instr_len(i_instr_len),
        .i_instr_done(i_instr_done), .i_sp_op(i_sp_op), .i_pop_data(i_pop_data), .i_irq_entry(i_irq_entry),
        .i_dco_in_use(i_dco_in_use), .i_xtal_in_use(i_xtal_in_use), .i_maskable_irq(i_maskable_irq),
        .o_src_data(o_src_data), .o_program_counter(o_program_counter), .o_stack_pointer(o_stack_pointer),
        .o_status_word(o_status_word), .o_core_halt(o_core_halt), .o_dc_generator_off(o_dc_generator_off),
        .o_loop_control_off(o_loop_control_off), .o_crystal_stop(o_crystal_stop), .o_irq_accept(o_irq_accept)
    );
    crf_mem_model u_crf_mem_model (.i_clk(i_clk), .i_we(mem_we), .i_addr(mem_addr), .i_wdata(mem_wdata),
                                   .o_rdata(i_pop_data));
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    task automatic op(input crf_op_t c, input logic [3:0] s, input logic [1:0] m, input logic [3:0] d,
                      input logic w, input logic b, input logic [15:0] r);
        @(posedge i_clk);
        i_op_valid <= 1'b1;
        i_op <= c;
        i_src_reg <= s;
        i_source_mode_bits <= m;
        i_dst_reg <= d;
        i_dst_write <= w;
        i_byte_op <= b;
        i_logic_result <= r;
        @(posedge i_clk);
        i_op_valid <= 1'b0;
        i_dst_write <= 1'b0;
        #1;
    endtask
    task automatic t_const;
        logic [15:0] k3 [4] = '{16'h0000, 16'h0001, 16'h0002, 16'hFFFF};
        logic [15:0] k2 [4] = '{16'h0000, 16'h0000, 16'h0004, 16'h0008};
        op(CRF_OP_LOGIC, 4'h0, 2'h0, 4'h3, 1'b1, 1'b0, 16'h5A5A);
        for (int i = 0; i < 4; i++) begin
            op(CRF_OP_MOV, 4'h3, i[1:0], 4'h0, 1'b0, 1'b0, 16'h0000);
            chk(o_src_data, k3[i], "r3 constant");
            op(CRF_OP_MOV, 4'h2, i[1:0], 4'h0, 1'b0, 1'b0, 16'h0000);
            if (i > 0) chk(o_src_data, k2[i], "r2 constant");
        end
        $display("test const done");
    endtask
    task automatic t_flag(input logic [15:0] pre, input crf_op_t c, input logic [1:0] m, input logic b,
                          input logic [3:0] f, input logic [15:0] res);
        op(CRF_OP_LOGIC, 4'h0, 2'h0, 4'h5, 1'b1, 1'b0, pre);
        op(c, 4'h3, m, 4'h5, 1'b1, b, 16'h0000);
        chk({12'h000, o_status_word[8], o_status_word[2:0]}, {12'h000, f}, "flags");
        op(CRF_OP_MOV, 4'h5, 2'h0, 4'h0, 1'b0, 1'b0, 16'h0000);
        chk(o_src_data, res, "result");
    endtask
    task automatic t_alu;
        t_flag(16'h7FFF, CRF_OP_ADD, 2'h1, 1'b0, 4'b1100, 16'h8000);
        t_flag(16'h8000, CRF_OP_ADD, 2'h3, 1'b0, 4'b1001, 16'h7FFF);
        t_flag(16'hFFFF, CRF_OP_ADD, 2'h1, 1'b0, 4'b0011, 16'h0000);
        t_flag(16'h127F, CRF_OP_ADD, 2'h1, 1'b1, 4'b1100, 16'h0080);
        t_flag(16'h8000, CRF_OP_SUB, 2'h1, 1'b0, 4'b1001, 16'h7FFF);
        t_flag(16'h0001, CRF_OP_CMP, 2'h1, 1'b0, 4'b0011, 16'h0001);
        $display("test alu done");
    endtask
    task automatic t_pc;
        logic [15:0] p;
        p = o_program_counter;
        @(posedge i_clk);
        i_instr_done <= 1'b1;
        i_instr_len <= 3'h6;
        @(posedge i_clk);
        i_instr_done <= 1'b0;
        #1;
        chk(o_program_counter, p + 16'h0006, "pc step");
        op(CRF_OP_LOGIC, 4'h0, 2'h0, 4'h0, 1'b1, 1'b0, 16'h1235);
        chk(o_program_counter, 16'h1234, "pc branch");
        op(CRF_OP_MOV, 4'h0, 2'h0, 4'h0, 1'b0, 1'b0, 16'h0000);
        chk(o_src_data, 16'h1234, "pc read");
        $display("test pc done");
    endtask
    task automatic t_sp;
        op(CRF_OP_LOGIC, 4'h0, 2'h0, 4'h1, 1'b1, 1'b0, 16'h0200);
        @(posedge i_clk);
        i_sp_op <= CRF_SP_PUSH;
        mem_we <= 1'b1;
        mem_addr <= o_stack_pointer - 16'h0002;
        mem_wdata <= 16'h0300;
        @(posedge i_clk);
        i_sp_op <= CRF_SP_NONE;
        mem_we <= 1'b0;
        #1;
        chk(o_stack_pointer, 16'h01FE, "push");
        @(posedge i_clk);
        i_sp_op <= CRF_SP_POP;
        i_op_valid <= 1'b1;
        i_dst_reg <= 4'h1;
        i_dst_write <= 1'b1;
        @(posedge i_clk);
        i_sp_op <= CRF_SP_NONE;
        i_op_valid <= 1'b0;
        i_dst_write <= 1'b0;
        #1;
        chk(o_stack_pointer, 16'h0300, "pop into sp");
        $display("test sp done");
    endtask
    task automatic t_sr;
        logic [3:0] lp;
        op(CRF_OP_LOGIC, 4'h0, 2'h0, 4'h2, 1'b1, 1'b0, 16'h00F8);
        op(CRF_OP_LOGIC, 4'h0, 2'h0, 4'h2, 1'b1, 1'b1, 16'h0000);
        chk(o_status_word, 16'h00F8, "byte sr write");
        lp = {o_core_halt, o_dc_generator_off, o_loop_control_off, o_crystal_stop};
        chk({12'h000, lp}, 16'h000F, "low power bits");
        @(posedge i_clk);
        i_maskable_irq <= 1'b1;
        i_dco_in_use <= 1'b1;
        i_xtal_in_use <= 1'b1;
        repeat (2) @(posedge i_clk);
        #1;
        lp = {1'b0, o_irq_accept, o_dc_generator_off, o_crystal_stop};
        chk({12'h000, lp}, 16'h0004, "in use");
        @(posedge i_clk);
        i_irq_entry <= 1'b1;
        @(posedge i_clk);
        i_irq_entry <= 1'b0;
        #1;
        chk(o_status_word, 16'h0048, "irq entry");
        op(CRF_OP_LOGIC, 4'h0, 2'h0, 4'h2, 1'b1, 1'b0, 16'h0000);
        @(posedge i_clk);
        #1;
        chk({15'h0000, o_irq_accept}, 16'h0000, "irq masked");
        $display("test sr done");
    endtask
    task automatic finish_test;
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            fails++;
            finish_test;
        end
    end
    initial begin
        {i_rst_b, i_op_valid, i_byte_op, i_dst_write, i_instr_done, i_irq_entry, mem_we} = 7'h00;
        {i_dco_in_use, i_xtal_in_use, i_maskable_irq, i_src_reg, i_dst_reg, i_source_mode_bits} = 13'h0000;
        {i_instr_len, i_logic_result, mem_addr, mem_wdata} = 51'h0;
        i_op = CRF_OP_MOV;
        i_sp_op = CRF_SP_NONE;
        repeat (5) @(posedge i_clk);
        i_rst_b <= 1'b1;
        t_const();
        t_alu();
        t_pc();
        t_sp();
        t_sr();
        finish_test();
    end
endmodule
bind crf_core_regs crf_core_regs_checker u_crf_core_regs_checker (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_op_valid(i_op_valid), .i_byte_op(i_byte_op), .i_dst_write(i_dst_write),
    .i_instr_done(i_instr_done), .i_irq_entry(i_irq_entry), .i_maskable_irq(i_maskable_irq),
    .o_core_halt(o_core_halt), .o_dc_generator_off(o_dc_generator_off), .o_crystal_stop(o_crystal_stop),
    .o_loop_control_off(o_loop_control_off), .o_irq_accept(o_irq_accept), .i_src_reg(i_src_reg),
    .i_dst_reg(i_dst_reg), .i_source_mode_bits(i_source_mode_bits), .i_instr_len(i_instr_len),
    .i_sp_op(i_sp_op), .i_pop_data(i_pop_data), .o_src_data(o_src_data),
    .o_program_counter(o_program_counter), .o_stack_pointer(o_stack_pointer), .o_status_word(o_status_word)
);
